/* core/ulpi_tail_regs_pkg.sv */
// Package with the register map, field layout and link command codes
// Assumes a single 100 MHz system clock; link timing is edge-detected.
package ulpi_tail_regs_pkg;
    // Register addresses as seen on the link (6-bit address field)
    localparam logic [5:0] ADDR_OTG_CTRL = 6'h0A;
    localparam logic [5:0] ADDR_RISE_EN = 6'h0D;
    localparam logic [5:0] ADDR_FALL_EN = 6'h10;
    localparam logic [5:0] ADDR_STATUS = 6'h13;
    localparam logic [5:0] ADDR_LATCH = 6'h14;
    localparam logic [5:0] ADDR_DEBUG = 6'h15;
    localparam logic [5:0] ADDR_SCRATCH = 6'h16;

    // Alias modes, offset from each register's base address
    localparam logic [1:0] ALIAS_WRITE = 2'h0;
    localparam logic [1:0] ALIAS_SET = 2'h1;
    localparam logic [1:0] ALIAS_CLEAR = 2'h2;

    // Field positions
    localparam int OTG_DPLUS_BIT = 1;
    localparam int OTG_DMINUS_BIT = 2;
    localparam int DETACH_BIT = 0;

    // Implemented-bit masks
    localparam logic [7:0] OTG_MASK = 8'h06;
    localparam logic [7:0] DETACH_MASK = 8'h01;
    localparam logic [7:0] LEVEL_MASK = 8'h03;

    // Reset values
    localparam logic [7:0] OTG_RESET = 8'h06;
    localparam logic [7:0] RISE_EN_RESET = 8'h01;
    localparam logic [7:0] FALL_EN_RESET = 8'h01;
    localparam logic [7:0] LATCH_RESET = 8'h00;
    localparam logic [7:0] SCRATCH_RESET = 8'h00;

    // Link command codes in data[7:6]
    localparam logic [1:0] CMD_REG_WRITE = 2'h2;
    localparam logic [1:0] CMD_REG_READ = 2'h3;

    // Synchroniser layout: link clock, stop, data, detach flag, line levels
    localparam int SYNC_WIDTH = 13;
    localparam int SY_CLK = 0;
    localparam int SY_STP = 1;
    localparam int SY_DATA = 2;
    localparam int SY_DETACH = 10;
    localparam int SY_LEVEL = 11;

    typedef enum logic [2:0] {
        LINK_IDLE = 3'b000,
        LINK_WR_DATA = 3'b001,
        LINK_WR_STOP = 3'b010,
        LINK_RD_TURN = 3'b011,
        LINK_RD_DATA = 3'b100,
        LINK_RD_END = 3'b101
    } link_state_t;
endpackage : ulpi_tail_regs_pkg

/* core/input_sync.sv */
// Two-flop synchroniser plus one history stage for edge finding
// Assumes inputs are asynchronous to sys_clk.
`timescale 1ns/10ps
module input_sync #(
    parameter int WIDTH = 1
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] level,
    output logic [WIDTH-1:0] levelPrev
);
    logic [WIDTH-1:0] meta_r;

    // First stage feeds only the second; third keeps history for edges
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            meta_r <= '0;
            level <= '0;
            levelPrev <= '0;
        end else begin
            meta_r <= asyncIn;
            level <= meta_r;
            levelPrev <= level;
        end
    end
endmodule : input_sync

/* core/ulpi_disconnect_irq_debug_regs.sv */
// Tail of the transceiver register bank reached over ULPI register access
// Assumes the link clock, link pins and analog flags are asynchronous inputs.
//
// Summary of operation
// - Enabled rising detach edge raises interrupt event
// - Detach events only while both pulldowns set
// - Enabled falling detach edge raises interrupt event
// - Enabled detach edge sets latch bit zero
// - Latch read returns contents then clears
// - Rising enable: write, set, clear aliases
// - Falling enable: write, set, clear aliases
// - Status byte read only, writes ignored
// - Debug byte shows line levels, rest zero
// - Debug byte at its address, read only
// - Eight-bit scratch byte resets to zero
// - Scratch aliases, no effect on anything else
// - Both pulldown enables reset to one
`timescale 1ns/10ps
module ulpi_disconnect_irq_debug_regs
    import ulpi_tail_regs_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ulpiClk,
    input wire logic ulpiStp,
    input wire logic [7:0] ulpiDataIn,
    output logic [7:0] ulpiDataOut,
    output logic ulpiDataOe,
    output logic ulpiDir,
    output logic ulpiNxt,
    input wire logic hostDetach,
    input wire logic [1:0] busLineLevel,
    output logic dplusPulldownEnable,
    output logic dminusPulldownEnable,
    output logic irqEvent
);
    import ulpi_tail_regs_pkg::*;

    // Apply a write, set or clear alias to a byte
    function automatic logic [7:0] aliasUpdate(input logic [7:0] cur, input logic [7:0] wdata,
                                               input logic [1:0] mode);
        logic [7:0] res;
        res = cur;
        unique case (mode)
            ALIAS_WRITE: res = wdata;
            ALIAS_SET: res = cur | wdata;
            ALIAS_CLEAR: res = cur & ~wdata;
            default: res = cur;
        endcase
        return res;
    endfunction : aliasUpdate

    // True when addr falls in the three-address alias window at base
    function automatic logic inAlias(input logic [5:0] addr, input logic [5:0] base);
        return (addr >= base) && (addr <= base + 6'h02);
    endfunction : inAlias

    logic [SYNC_WIDTH-1:0] syLevel;
    logic [SYNC_WIDTH-1:0] syPrev;

    // Every outside input passes two flops before use
    input_sync #(.WIDTH(SYNC_WIDTH)) u_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .asyncIn({busLineLevel, hostDetach, ulpiDataIn, ulpiStp, ulpiClk}),
        .level(syLevel),
        .levelPrev(syPrev)
    );

    logic linkEdge;
    logic detachRise;
    logic detachFall;
    logic detachLevel;
    logic linkStp;
    logic [7:0] linkData;
    logic [1:0] lineLevel;

    // Edges found on the synchronised copies only
    assign linkEdge = syLevel[SY_CLK] & ~syPrev[SY_CLK];
    assign detachLevel = syLevel[SY_DETACH];
    assign detachRise = syLevel[SY_DETACH] & ~syPrev[SY_DETACH];
    assign detachFall = ~syLevel[SY_DETACH] & syPrev[SY_DETACH];
    assign linkStp = syLevel[SY_STP];
    assign linkData = syLevel[SY_DATA +: 8];
    assign lineLevel = syLevel[SY_LEVEL +: 2];

    link_state_t state_r, state_nxt;
    logic [5:0] addr_r, addr_nxt;
    logic [7:0] wdata_r, wdata_nxt;
    logic [7:0] otgCtrl_r, otgCtrl_nxt;
    logic [7:0] riseEn_r, riseEn_nxt;
    logic [7:0] fallEn_r, fallEn_nxt;
    logic [7:0] latch_r, latch_nxt;
    logic [7:0] scratch_r, scratch_nxt;
    logic [7:0] dataOut_r, dataOut_nxt;
    logic dataOe_r, dataOe_nxt;
    logic dir_r, dir_nxt;
    logic nxt_r, nxt_nxt;
    logic irq_r, irq_nxt;
    logic [7:0] readByte;
    logic [7:0] statusByte;
    logic [7:0] debugByte;
    logic hostMode;
    logic riseEvent;
    logic fallEvent;
    logic wrStrobe;
    logic latchRead;

    // Host mode and qualified detach events
    assign hostMode = otgCtrl_r[OTG_DPLUS_BIT] & otgCtrl_r[OTG_DMINUS_BIT];
    assign riseEvent = hostMode & detachRise & riseEn_r[DETACH_BIT];
    assign fallEvent = hostMode & detachFall & fallEn_r[DETACH_BIT];
    assign statusByte = {7'h00, detachLevel};
    assign debugByte = {6'h00, lineLevel} & LEVEL_MASK;

    // Read decode; unmapped addresses read as zero
    always_comb begin
        readByte = 8'h00;
        if (inAlias(addr_r, ADDR_OTG_CTRL)) begin
            readByte = otgCtrl_r;
        end else if (inAlias(addr_r, ADDR_RISE_EN)) begin
            readByte = riseEn_r;
        end else if (inAlias(addr_r, ADDR_FALL_EN)) begin
            readByte = fallEn_r;
        end else if (addr_r == ADDR_STATUS) begin
            readByte = statusByte;
        end else if (addr_r == ADDR_LATCH) begin
            readByte = latch_r;
        end else if (addr_r == ADDR_DEBUG) begin
            readByte = debugByte;
        end else if (inAlias(addr_r, ADDR_SCRATCH)) begin
            readByte = scratch_r;
        end
    end

    // Link sequencer: register write and read over the shared data bus
    always_comb begin
        state_nxt = state_r;
        addr_nxt = addr_r;
        wdata_nxt = wdata_r;
        dataOut_nxt = dataOut_r;
        dataOe_nxt = dataOe_r;
        dir_nxt = dir_r;
        nxt_nxt = nxt_r;
        wrStrobe = 1'b0;
        latchRead = 1'b0;
        if (linkEdge) begin
            unique case (state_r)
                LINK_IDLE: begin
                    if (linkData[7:6] == CMD_REG_WRITE) begin
                        addr_nxt = linkData[5:0];
                        nxt_nxt = 1'b1;
                        state_nxt = LINK_WR_DATA;
                    end else if (linkData[7:6] == CMD_REG_READ) begin
                        addr_nxt = linkData[5:0];
                        nxt_nxt = 1'b1;
                        state_nxt = LINK_RD_TURN;
                    end
                end
                LINK_WR_DATA: begin
                    // Stop here aborts the write without touching state
                    wdata_nxt = linkData;
                    nxt_nxt = 1'b0;
                    state_nxt = linkStp ? LINK_IDLE : LINK_WR_STOP;
                end
                LINK_WR_STOP: begin
                    if (linkStp) begin
                        wrStrobe = 1'b1;
                        state_nxt = LINK_IDLE;
                    end
                end
                LINK_RD_TURN: begin
                    // Turnaround cycle: take the bus but do not drive yet
                    nxt_nxt = 1'b0;
                    dir_nxt = 1'b1;
                    state_nxt = LINK_RD_DATA;
                end
                LINK_RD_DATA: begin
                    dataOut_nxt = readByte;
                    dataOe_nxt = 1'b1;
                    latchRead = (addr_r == ADDR_LATCH);
                    state_nxt = LINK_RD_END;
                end
                LINK_RD_END: begin
                    dataOe_nxt = 1'b0;
                    dir_nxt = 1'b0;
                    dataOut_nxt = 8'h00;
                    state_nxt = LINK_IDLE;
                end
                default: state_nxt = LINK_IDLE;
            endcase
        end
    end

    // Register updates; status, latch and debug ignore writes
    always_comb begin
        otgCtrl_nxt = otgCtrl_r;
        riseEn_nxt = riseEn_r;
        fallEn_nxt = fallEn_r;
        scratch_nxt = scratch_r;
        if (wrStrobe) begin
            if (inAlias(addr_r, ADDR_OTG_CTRL)) begin
                otgCtrl_nxt = aliasUpdate(otgCtrl_r, wdata_r, 2'(addr_r - ADDR_OTG_CTRL)) & OTG_MASK;
            end
            if (inAlias(addr_r, ADDR_RISE_EN)) begin
                riseEn_nxt = aliasUpdate(riseEn_r, wdata_r, 2'(addr_r - ADDR_RISE_EN))
                    & DETACH_MASK;
            end
            if (inAlias(addr_r, ADDR_FALL_EN)) begin
                fallEn_nxt = aliasUpdate(fallEn_r, wdata_r, 2'(addr_r - ADDR_FALL_EN))
                    & DETACH_MASK;
            end
            if (inAlias(addr_r, ADDR_SCRATCH)) begin
                scratch_nxt = aliasUpdate(scratch_r, wdata_r, 2'(addr_r - ADDR_SCRATCH));
            end
        end
        // A new event in the clearing read cycle survives the clear
        latch_nxt = (latchRead ? 8'h00 : latch_r)
            | {7'h00, riseEvent | fallEvent};
        irq_nxt = riseEvent | fallEvent;
    end

    // State and register flops
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_r <= LINK_IDLE;
            addr_r <= 6'h00;
            wdata_r <= 8'h00;
            otgCtrl_r <= OTG_RESET;
            riseEn_r <= RISE_EN_RESET;
            fallEn_r <= FALL_EN_RESET;
            latch_r <= LATCH_RESET;
            scratch_r <= SCRATCH_RESET;
            dataOut_r <= 8'h00;
            dataOe_r <= 1'b0;
            dir_r <= 1'b0;
            nxt_r <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            addr_r <= addr_nxt;
            wdata_r <= wdata_nxt;
            otgCtrl_r <= otgCtrl_nxt;
            riseEn_r <= riseEn_nxt;
            fallEn_r <= fallEn_nxt;
            latch_r <= latch_nxt;
            scratch_r <= scratch_nxt;
            dataOut_r <= dataOut_nxt;
            dataOe_r <= dataOe_nxt;
            dir_r <= dir_nxt;
            nxt_r <= nxt_nxt;
            irq_r <= irq_nxt;
        end
    end

    // Outputs straight from flops
    assign ulpiDataOut = dataOut_r;
    assign ulpiDataOe = dataOe_r;
    assign ulpiDir = dir_r;
    assign ulpiNxt = nxt_r;
    assign dplusPulldownEnable = otgCtrl_r[OTG_DPLUS_BIT];
    assign dminusPulldownEnable = otgCtrl_r[OTG_DMINUS_BIT];
    assign irqEvent = irq_r;
endmodule : ulpi_disconnect_irq_debug_regs

/* dv/ulpi_tail_regs_props.sv */
// Checker for handshake widths and detach event pulses of the register tail
// Assumes 16 sys_clk cycles per link period; bound onto the register tail module.
`timescale 1ns/10ps
module ulpi_tail_regs_props (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic hostDetach,
    input wire logic [7:0] ulpiDataOut,
    input wire logic ulpiDataOe,
    input wire logic ulpiDir,
    input wire logic ulpiNxt,
    input wire logic dplusPulldownEnable,
    input wire logic dminusPulldownEnable,
    input wire logic irqEvent
);
    logic detPrev;
    logic [2:0] detAge;
    logic [1:0] upAge;
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    // Cycles since the flag moved; an event far from any edge is bogus
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            detPrev <= 1'b0;
            detAge <= 3'h7;
            upAge <= 2'h0;
        end else begin
            detPrev <= hostDetach;
            detAge <= (hostDetach != detPrev) ? 3'h0 : detAge + {2'h0, detAge != 3'h7};
            upAge <= upAge + {1'b0, upAge != 2'h3};
        end
    end
    irq_one_pulse_a: assert property (irqEvent |=> !irqEvent)
        else $error("event pulse too long");
    // Event flop is loaded from the host mode of the cycle before
    irq_host_only_a: assert property (
        irqEvent |-> $past(dplusPulldownEnable) && $past(dminusPulldownEnable))
        else $error("event outside host mode");
    irq_near_edge_a: assert property (irqEvent |-> detAge <= 3'h5)
        else $error("event without detach edge");
    pulldown_reset_a: assert property (upAge < 2'h2 |-> dplusPulldownEnable && dminusPulldownEnable)
        else $error("pulldown not set after reset");
    data_under_dir_a: assert property (ulpiDataOe |-> ulpiDir && !ulpiNxt)
        else $error("data driven outside turnaround");
    data_idle_zero_a: assert property (!ulpiDataOe |-> ulpiDataOut == 8'h00)
        else $error("data not zero when idle");
    oe_one_period_a: assert property ($rose(ulpiDataOe) |-> ulpiDataOe[*8] ##[4:12] !ulpiDataOe)
        else $error("read data width wrong");
    dir_two_period_a: assert property ($rose(ulpiDir) |-> ulpiDir[*8] ##[20:28] !ulpiDir)
        else $error("turnaround width wrong");
    nxt_one_period_a: assert property ($rose(ulpiNxt) |-> ulpiNxt[*8] ##[4:12] !ulpiNxt)
        else $error("command accept width wrong");
    cover property (irqEvent);
    cover property ($rose(ulpiDataOe));
    cover property ($rose(ulpiNxt) ##[1:40] !ulpiNxt);
endmodule : ulpi_tail_regs_props

/* dv/ulpi_link_model.sv */
// Link controller model: clock runs only inside frames
// Assumes the device answers well within half a link period.
`timescale 1ns/10ps
module ulpi_link_model (
    output logic ulpiClk,
    output logic ulpiStp,
    output logic [7:0] ulpiDataIn,
    input wire logic [7:0] ulpiDataOut
);
    initial begin
        ulpiClk = 1'b0;
        ulpiStp = 1'b0;
        ulpiDataIn = 8'h00;
    end
    // One link period; returns what the device shows at the rising edge
    task automatic tick(input logic [7:0] d, input logic s, output logic [7:0] r);
        ulpiDataIn = d;
        ulpiStp = s;
        #80 r = ulpiDataOut;
        ulpiClk = 1'b1;
        #80 ulpiClk = 1'b0;
    endtask : tick
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] r;
        tick(8'h80 | a, 1'b0, r);
        tick(d, 1'b0, r);
        tick(d, 1'b1, r);
        ulpiStp = 1'b0;
        ulpiDataIn = ~d;
        #10; // Next frame must not drive the same pins in this time step
    endtask : wr
    // Bus released after the command: inverse pattern, never stale data
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        tick(8'hC0 | a, 1'b0, q);
        repeat (3) tick(8'h3F ^ a, 1'b0, q);
    endtask : rd
endmodule : ulpi_link_model

/* dv/tb_top.sv */
// Top bench: link model, register tail and an integer model of the map
// Assumes link tasks return with the link clock low and the device idle.
`timescale 1ns/10ps
module tb_top;
    import ulpi_tail_regs_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic hostDetach = 1'b0;
    logic [1:0] busLineLevel = 2'h0;
    logic ulpiClk, ulpiStp, ulpiDataOe, ulpiDir, ulpiNxt, irqEvent;
    logic dplusPulldownEnable, dminusPulldownEnable;
    logic [7:0] ulpiDataIn, ulpiDataOut, q;
    int fail_count = 0;
    int num_checks = 0;
    int evCnt = 0;
    int evExp = 0;
    int cyc = 0;
    int latchM = 0;
    int regM [int];
    ulpi_link_model ulpi_link_model_i (.ulpiClk(ulpiClk), .ulpiStp(ulpiStp),
        .ulpiDataIn(ulpiDataIn), .ulpiDataOut(ulpiDataOut));
    ulpi_disconnect_irq_debug_regs ulpi_disconnect_irq_debug_regs_i (.sys_clk(sys_clk),
        .rst(rst), .ulpiClk(ulpiClk), .ulpiStp(ulpiStp), .ulpiDataIn(ulpiDataIn),
        .ulpiDataOut(ulpiDataOut), .ulpiDataOe(ulpiDataOe), .ulpiDir(ulpiDir),
        .ulpiNxt(ulpiNxt), .hostDetach(hostDetach), .busLineLevel(busLineLevel),
        .dplusPulldownEnable(dplusPulldownEnable), .dminusPulldownEnable(dminusPulldownEnable),
        .irqEvent(irqEvent));
    always #5 sys_clk = ~sys_clk;
    // Event counting and hang guard
    always @(posedge sys_clk) begin
        cyc++;
        if (irqEvent === 1'b1) evCnt++;
        if (cyc == 20000) begin
            fail_count++;
            finish_test();
        end
    end
    function automatic int base(input int a);
        if (a >= 8'h16 && a <= 8'h18) return 8'h16;
        if (a >= 8'h0A && a <= 8'h12) return a - (a - 8'h0A) % 3;
        return a;
    endfunction : base
    function automatic int mask(input int b);
        return b == 8'h16 ? 8'hFF : b == 8'h0A ? 8'h06 : (b == 8'h0D || b == 8'h10) ? 1 : 0;
    endfunction : mask
    function automatic int expv(input int a);
        if (mask(base(a)) != 0) return regM[base(a)];
        if (a == 8'h13) return int'(hostDetach);
        if (a == 8'h14) return latchM;
        if (a == 8'h15) return int'(busLineLevel);
        return 0;
    endfunction : expv
    task automatic chk(input string n, input int e, input logic [7:0] s);
        num_checks++;
        if (s !== 8'(e)) begin
            fail_count++;
            $display("MISMATCH %s exp %0h got %0h", n, e, s);
        end
    endtask : chk
    // Model follows write, set and clear aliases; other places stay put
    task automatic wreg(input int a, input int d);
        int b;
        b = base(a);
        ulpi_link_model_i.wr(8'(a), 8'(d));
        if (a == b) regM[b] = d & mask(b);
        else if (a == b + 1) regM[b] = regM[b] | (d & mask(b));
        else regM[b] = regM[b] & ~d;
    endtask : wreg
    task automatic rreg(input int a);
        ulpi_link_model_i.rd(8'(a), q);
        chk($sformatf("reg%0h", a), expv(a), q);
        if (a == 8'h14) latchM = 0;
    endtask : rreg
    task automatic det(input logic v);
        @(posedge sys_clk);
        #1 hostDetach = v;
        if (regM[8'h0A] == 6 && regM[v ? 8'h0D : 8'h10] == 1) begin
            evExp++;
            latchM = 1;
        end
        repeat (8) @(posedge sys_clk);
        #1; // Keep later stimulus off the sampling edge
    endtask : det
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : finish_test
    initial begin
        void'($urandom(7784));
        regM[8'h0A] = 6;
        regM[8'h0D] = 1;
        regM[8'h10] = 1;
        regM[8'h16] = 0;
        repeat (20) @(posedge sys_clk);
        #1 rst = 1'b0;
        repeat (5) @(posedge sys_clk);
        #1;
        for (int a = 8'h0A; a <= 8'h18; a++) rreg(a);
        $display("test reset values done");
        for (int a = 8'h0A; a <= 8'h19; a++) begin
            wreg(a, $urandom);
            rreg(a);
        end
        $display("test aliases done");
        for (int i = 0; i < 8; i++) begin
            wreg(8'h0A, i[2] ? 6 : $urandom);
            wreg(8'h0D, i & 1);
            wreg(8'h10, i >> 1);
            busLineLevel = 2'($urandom);
            det(1'b1);
            rreg(8'h13);
            rreg(8'h15);
            chk("pulldowns", regM[8'h0A] >> 1,
                {6'h00, dminusPulldownEnable, dplusPulldownEnable});
            det(1'b0);
            rreg(8'h13);
            wreg(8'h14, 8'hFF);
            rreg(8'h14);
            rreg(8'h14);
            chk("events", evExp, 8'(evCnt));
        end
        $display("test detach events done");
        finish_test();
    end
endmodule : tb_top
bind ulpi_disconnect_irq_debug_regs ulpi_tail_regs_props ulpi_tail_regs_props_i (
    .sys_clk(sys_clk), .rst(rst), .hostDetach(hostDetach), .ulpiDataOut(ulpiDataOut),
    .ulpiDataOe(ulpiDataOe), .ulpiDir(ulpiDir), .ulpiNxt(ulpiNxt),
    .dplusPulldownEnable(dplusPulldownEnable), .dminusPulldownEnable(dminusPulldownEnable),
    .irqEvent(irqEvent));
